// *** src/tcp_phy_enable.sv ***
`timescale 1ns/10ps
// How it works
// - select low: attach plus orientation drive enables
// - select high: orientation a/b attaches drive enables
// - polarity low: all attach inputs active high
// - polarity high: all attach inputs inverted first
// - scheme 2: b attach asserted enables phy b
// - scheme 2: b attach deasserted keeps phy b off
// - polarity low: b level 1 on, 0 off
// - polarity high: b level 1 off, 0 on
// - scheme select input has internal pull-down
// - scheme 1: port attach enables its phy
// - scheme 1: orientation 1 picks a, 0 b
// - scheme 2: a attach asserted enables phy a
module tcp_phy_enable (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// scheme 1 pins
	input wire tcp_pkg::tcp_port_t PORT_ATTACH_IN,
	input wire logic ORIENTATION_SEL_IN,
	// scheme 2 pins
	input wire logic ORIENT_A_ATTACH_IN,
	input wire logic ORIENT_B_ATTACH_IN,
	// configuration pins
	input wire logic ATTACH_POLARITY_IN,
	input wire logic CONTROL_SCHEME_SEL,
	// phy enables, one bit per port
	output tcp_pkg::tcp_port_t PHY_A_EN,
	output tcp_pkg::tcp_port_t PHY_B_EN,
	// pad pull-down controls
	output logic POLARITY_PULLDOWN_EN,
	output logic SCHEME_PULLDOWN_EN
);
	import tcp_pkg::*;

	tcp_sync_if sync_bus ();
	tcp_state_e state_reg;
	logic [1:0] fill_cnt_reg;
	tcp_port_t phy_a_en_reg;
	tcp_port_t phy_b_en_reg;
	tcp_port_t phy_a_en_next;
	tcp_port_t phy_b_en_next;
	logic [ACT_W-1:0] act;
	tcp_port_t attach;
	logic orient;
	logic mux_a;
	logic mux_b;
	logic pol;
	logic scheme;

	// every pin, straps included, crosses into the clock domain
	assign sync_bus.raw = {CONTROL_SCHEME_SEL, ATTACH_POLARITY_IN, ORIENT_B_ATTACH_IN,
		ORIENT_A_ATTACH_IN, ORIENTATION_SEL_IN, PORT_ATTACH_IN};

	tcp_sync u_sync (
		.clk(SYS_CLK),
		.rst(RST),
		.bus(sync_bus)
	);

	// pull-downs sit in the pad; unconnected pins read low
	// pad controls, not logic, so they stay on through reset as well
	assign POLARITY_PULLDOWN_EN = PULLDOWN_ON;
	assign SCHEME_PULLDOWN_EN = PULLDOWN_ON;

	// polarity flips every attach-type input before decode
	// the straps pass the same two flops, so a polarity flip and the pins
	// it inverts reach the decode in the same cycle
	assign pol = sync_bus.synced[IDX_POL];
	assign scheme = sync_bus.synced[IDX_SCHEME];
	assign act = sync_bus.synced[ACT_W-1:0] ^ {ACT_W{pol}};
	assign attach = act[IDX_ATTACH +: PORT_COUNT];
	assign orient = act[IDX_ORIENT];
	assign mux_a = act[IDX_MUX_A];
	assign mux_b = act[IDX_MUX_B];

	// startup sequencer: the flops hold reset zeros until filled
	// one spare cycle past the fill costs nothing and keeps the stage
	// count in one place; a wait two cycles shorter would decode stale zeros
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_reg <= ST_HOLD;
		end else begin
			unique case (state_reg)
				ST_HOLD: state_reg <= ST_FILL;
				ST_FILL: begin
					if (fill_cnt_reg == FILL_LAST) begin
						state_reg <= ST_RUN;
					end
				end
				ST_RUN: state_reg <= ST_RUN;
				default: state_reg <= ST_HOLD;
			endcase
		end
	end

	// counts fill cycles so the stage count stays in the package
	// two bits hold any fill length up to four stages
	always_ff @(posedge SYS_CLK) begin
		if (RST || state_reg != ST_FILL) begin
			fill_cnt_reg <= 2'h0;
		end else begin
			fill_cnt_reg <= fill_cnt_reg + 2'h1;
		end
	end

	// enable decode; the unused scheme's inputs never reach it
	always_comb begin
		phy_a_en_next = PHY_OFF;
		phy_b_en_next = PHY_OFF;
		if (state_reg == ST_RUN) begin
			if (scheme == SCHEME_1) begin
				phy_a_en_next = attach & {PORT_COUNT{orient}};
				phy_b_en_next = attach & {PORT_COUNT{~orient}};
			end else begin
				// only the muxed port has scheme 2 inputs; others stay off
				phy_a_en_next[MUX_PORT] = mux_a;
				phy_b_en_next[MUX_PORT] = mux_b;
			end
		end
	end

	// registered enables: no glitch reaches the phy power switch
	// costs one cycle of latency, far below any attach debounce
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			phy_a_en_reg <= PHY_OFF;
			phy_b_en_reg <= PHY_OFF;
		end else begin
			phy_a_en_reg <= phy_a_en_next;
			phy_b_en_reg <= phy_b_en_next;
		end
	end

	assign PHY_A_EN = phy_a_en_reg;
	assign PHY_B_EN = phy_b_en_reg;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	// decode checks: registered enables against the decode one edge back, plus pull-down and startup-off

	scheme1_ignore_a: assert property (state_reg == ST_RUN && !scheme
		|=> PHY_A_EN == $past(attach & {PORT_COUNT{orient}}))
		else $error("scheme 1 phy a enable not from attach and orientation");
	scheme2_ignore_a: assert property (state_reg == ST_RUN && scheme
		|=> PHY_A_EN[2:1] == 2'h0 && PHY_B_EN[2:1] == 2'h0)
		else $error("scheme 2 drove a port without scheme 2 inputs");
	pol_low_a: assert property (state_reg == ST_RUN && !pol && !scheme
		&& sync_bus.synced[IDX_ATTACH] && sync_bus.synced[IDX_ORIENT] |=> PHY_A_EN[0])
		else $error("active high attach did not enable phy a");
	pol_high_a: assert property (state_reg == ST_RUN && pol && !scheme
		&& !sync_bus.synced[IDX_ATTACH] && !sync_bus.synced[IDX_ORIENT] |=> PHY_A_EN[0])
		else $error("active low attach did not enable phy a");
	mux_b_on_a: assert property (state_reg == ST_RUN && scheme && mux_b
		|=> PHY_B_EN[MUX_PORT])
		else $error("orientation b attach did not enable phy b");
	mux_b_off_a: assert property (state_reg == ST_RUN && scheme && !mux_b
		|=> !PHY_B_EN[MUX_PORT])
		else $error("phy b powered without orientation b attach");
	b_level_low_a: assert property (state_reg == ST_RUN && scheme && !pol
		|=> PHY_B_EN[MUX_PORT] == $past(sync_bus.synced[IDX_MUX_B]))
		else $error("phy b does not follow b level under low polarity");
	b_level_high_a: assert property (state_reg == ST_RUN && scheme && pol
		|=> PHY_B_EN[MUX_PORT] == !$past(sync_bus.synced[IDX_MUX_B]))
		else $error("phy b does not follow inverted b level");
	pulldown_on_a: assert property (POLARITY_PULLDOWN_EN && SCHEME_PULLDOWN_EN)
		else $error("pad pull-down released");
	scheme1_b_a: assert property (state_reg == ST_RUN && !scheme
		|=> PHY_B_EN == $past(attach & {PORT_COUNT{~orient}}))
		else $error("scheme 1 phy b enable not from attach and orientation");
	one_phy_a: assert property (!scheme ##1 !$past(scheme) |-> (PHY_A_EN & PHY_B_EN) == 3'h0)
		else $error("both phys of one port enabled in scheme 1");
	mux_a_on_a: assert property (state_reg == ST_RUN && scheme
		|=> PHY_A_EN[MUX_PORT] == $past(mux_a))
		else $error("phy a does not follow orientation a attach");
	startup_off_a: assert property ($fell(RST) |-> (PHY_A_EN == 3'h0 && PHY_B_EN == 3'h0)[*4])
		else $error("phy enabled before synchronised inputs are valid");

	// sequencer checks: run comes on time, stays, and gates the decode
	run_reached_a: assert property ($fell(RST) |-> ##3 state_reg == ST_RUN)
		else $error("decode not running three edges after reset release");
	run_holds_a: assert property (state_reg == ST_RUN |=> state_reg == ST_RUN)
		else $error("decode left the run state without reset");
	state_legal_a: assert property (state_reg inside {ST_HOLD, ST_FILL, ST_RUN})
		else $error("sequencer holds an unused state code");
	fill_clear_a: assert property (state_reg != ST_FILL |=> fill_cnt_reg == 2'h0)
		else $error("fill counter not cleared outside fill");
	early_off_a: assert property (state_reg != ST_RUN
		|=> PHY_A_EN == PHY_OFF && PHY_B_EN == PHY_OFF)
		else $error("phy enabled before the decode was running");
	fill_end_a: assert property (state_reg == ST_FILL && fill_cnt_reg == FILL_LAST
		|=> state_reg == ST_RUN)
		else $error("sequencer did not leave fill after the last stage");

	// wider decode checks: whole ports, both schemes, scheme 2 pin levels
	port_attach_a: assert property (state_reg == ST_RUN && !scheme
		|=> (PHY_A_EN | PHY_B_EN) == $past(attach))
		else $error("scheme 1 port power does not follow its attach");
	orient_b_a: assert property (state_reg == ST_RUN && !scheme && !orient
		|=> PHY_A_EN == PHY_OFF)
		else $error("phy a powered while orientation selects b");
	scheme2_idle_a: assert property (state_reg == ST_RUN && scheme && !mux_a && !mux_b
		|=> PHY_A_EN == PHY_OFF && PHY_B_EN == PHY_OFF)
		else $error("scheme 2 powered a phy with no orientation attach");
	mux_a_low_a: assert property (state_reg == ST_RUN && scheme && !pol
		&& sync_bus.synced[IDX_MUX_A] |=> PHY_A_EN[MUX_PORT])
		else $error("active high orientation a attach did not enable phy a");
	mux_a_high_a: assert property (state_reg == ST_RUN && scheme && pol
		&& !sync_bus.synced[IDX_MUX_A] |=> PHY_A_EN[MUX_PORT])
		else $error("active low orientation a attach did not enable phy a");

	// main scenarios: orientation flip, scheme 2, inverted pins, restart
	s1_attach_c: cover property (state_reg == ST_RUN && !scheme && PHY_A_EN[0] ##1 PHY_B_EN[0]);
	s2_attach_c: cover property (state_reg == ST_RUN && scheme && PHY_B_EN[MUX_PORT]);
	inverted_c: cover property (state_reg == ST_RUN && pol && PHY_A_EN != 3'h0);
	startup_c: cover property ($fell(RST) ##3 state_reg == ST_RUN);
	both_mux_c: cover property (state_reg == ST_RUN && scheme && PHY_A_EN[MUX_PORT]
		&& PHY_B_EN[MUX_PORT]);
endmodule : tcp_phy_enable

// *** src/tcp_pkg.sv ***
package tcp_pkg;
	// number of type-c ports served by the per-port attach inputs
	localparam int PORT_COUNT = 3;
	// two flops between a pin and any decode logic
	localparam int SYNC_STAGES = 2;
	// layout of the synchronised input vector
	localparam int IN_W = 8;
	localparam int IDX_ATTACH = 0; // three bits, one per port
	localparam int IDX_ORIENT = 3;
	localparam int IDX_MUX_A = 4;
	localparam int IDX_MUX_B = 5;
	localparam int IDX_POL = 6;
	localparam int IDX_SCHEME = 7;
	// width of the attach-type bits that the polarity input inverts
	localparam int ACT_W = 6;
	// port that the orientation-a/b attach inputs belong to
	localparam int MUX_PORT = 0;
	// decode states, gray along hold -> fill -> run
	typedef enum logic [1:0] {
		ST_HOLD = 2'h0,
		ST_FILL = 2'h1,
		ST_RUN = 2'h3
	} tcp_state_e;
	typedef logic [PORT_COUNT-1:0] tcp_port_t;
	// count on the last of the fill cycles; fill lasts one cycle more than this value
	localparam logic [1:0] FILL_LAST = 2'(SYNC_STAGES - 1);
	localparam tcp_port_t PHY_OFF = '0;
	// internal pad pull-downs are permanently on
	localparam logic PULLDOWN_ON = 1'b1;
	// scheme select levels
	localparam logic SCHEME_1 = 1'b0;
	localparam logic SCHEME_2 = 1'b1;
endpackage : tcp_pkg

// *** src/tcp_sync_if.sv ***
`timescale 1ns/10ps
// raw pin levels in, synchronised levels out
interface tcp_sync_if;
	import tcp_pkg::*;
	logic [IN_W-1:0] raw;
	logic [IN_W-1:0] synced;
	modport src (input raw, output synced);
	modport dst (output raw, input synced);
endinterface : tcp_sync_if

// *** src/tcp_sync.sv ***
`timescale 1ns/10ps
module tcp_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin levels in, stable levels out
	tcp_sync_if.src bus
);
	import tcp_pkg::*;

	logic [IN_W-1:0] meta_reg;
	logic [IN_W-1:0] stable_reg;

	// two flops per bit; the first is read only by the second
	genvar gi;
	generate
		for (gi = 0; gi < IN_W; gi++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_reg[gi] <= 1'b0;
					stable_reg[gi] <= 1'b0;
				end else begin
					meta_reg[gi] <= bus.raw[gi];
					stable_reg[gi] <= meta_reg[gi];
				end
			end
		end
	endgenerate

	assign bus.synced = stable_reg;

	sync_delay_a: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) && !$past(rst, 2) |-> stable_reg == $past(bus.raw, 2))
		else $error("synchroniser output is not the pin level two cycles back");
endmodule : tcp_sync

// *** tb/tcp_attach_model.sv ***
`timescale 1ns/10ps
// external attach detector: detected states in, hub pin levels out
module tcp_attach_model (
	// strap level seen by both sides
	input wire logic pol,
	// detected states, true means attached or orientation a
	input wire logic [2:0] att,
	input wire logic ori,
	input wire logic mux_a,
	input wire logic mux_b,
	// pin levels toward the hub
	output logic [2:0] att_pin,
	output logic ori_pin,
	output logic mux_a_pin,
	output logic mux_b_pin
);
	// strap high means the detector signals active low on every pin
	assign att_pin = att ^ {3{pol}};
	assign ori_pin = ori ^ pol;
	assign mux_a_pin = mux_a ^ pol;
	assign mux_b_pin = mux_b ^ pol;
endmodule : tcp_attach_model

// *** tb/test_typec_attach_phy_enable.sv ***
`timescale 1ns/10ps
module test_typec_attach_phy_enable;
	import tcp_pkg::*;
	logic SYS_CLK = 1'b0;
	logic RST = 1'b1;
	logic pol = 1'b0;
	logic sch = 1'b0;
	logic ori = 1'b1;
	logic ma = 1'b0;
	logic mb = 1'b0;
	logic [2:0] att = 3'h7;
	logic [2:0] att_pin;
	logic ori_pin, ma_pin, mb_pin, pd_pol, pd_sch;
	tcp_port_t phy_a, phy_b;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;

	tcp_attach_model model (.pol(pol), .att(att), .ori(ori), .mux_a(ma), .mux_b(mb),
		.att_pin(att_pin), .ori_pin(ori_pin), .mux_a_pin(ma_pin), .mux_b_pin(mb_pin));

	tcp_phy_enable dut (.SYS_CLK(SYS_CLK), .RST(RST), .PORT_ATTACH_IN(att_pin),
		.ORIENTATION_SEL_IN(ori_pin), .ORIENT_A_ATTACH_IN(ma_pin),
		.ORIENT_B_ATTACH_IN(mb_pin), .ATTACH_POLARITY_IN(pol),
		.CONTROL_SCHEME_SEL(sch), .PHY_A_EN(phy_a), .PHY_B_EN(phy_b),
		.POLARITY_PULLDOWN_EN(pd_pol), .SCHEME_PULLDOWN_EN(pd_sch));

	// 10 MHz system clock
	initial begin
		forever #50 SYS_CLK = ~SYS_CLK;
	end

	// compare one value, count it, report a miss at once
	task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t enable seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// set strap and detector states, then wait out sync plus output register
	task automatic apply(input logic p, s, o, a, b, input logic [2:0] t);
		@(posedge SYS_CLK);
		pol <= p;
		sch <= s;
		ori <= o;
		ma <= a;
		mb <= b;
		att <= t;
		repeat (4) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
		chk(phy_a, s ? {2'h0, a} : t & {3{o}});
		chk(phy_b, s ? {2'h0, b} : t & {3{~o}});
	endtask : apply

	// verdict and end of run
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	// hang guard, well above the roughly 1300 cycles the sequence needs
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			close_out();
		end
	end

	// main sequence: reset gating, straps, then every input combination
	initial begin
		repeat (20) @(posedge SYS_CLK);
		RST <= 1'b0;
		// pins already show an attach, yet enables stay off while sync fills
		for (int i = 0; i < 3; i++) begin
			@(posedge SYS_CLK);
			@(negedge SYS_CLK);
			chk(phy_a | phy_b, 3'h0);
		end
		@(posedge SYS_CLK);
		@(negedge SYS_CLK);
		chk(phy_a, 3'h7);
		chk({1'b0, pd_pol, pd_sch}, 3'h3);
		// walks polarity, scheme, orientation, both mux attaches and all ports
		// orientation on the low bit so one step moves a powered port from a to b
		for (int k = 0; k < 256; k++) begin
			apply(k[7], k[6], ~k[0], k[5], k[4], k[3:1]);
		end
		// reset again mid-run: enables drop and stay off while sync refills
		@(posedge SYS_CLK);
		RST <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		RST <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			@(posedge SYS_CLK);
			@(negedge SYS_CLK);
			chk(phy_a | phy_b, 3'h0);
		end
		// last step left scheme 2 with both orientation attaches asserted
		@(posedge SYS_CLK);
		@(negedge SYS_CLK);
		chk(phy_a, 3'h1);
		chk(phy_b, 3'h1);
		close_out();
	end
endmodule : test_typec_attach_phy_enable
